// ---- src/lsr_consts.vh ----
`ifndef LSR_CONSTS_VH
`define LSR_CONSTS_VH
// Register indices (printed offsets are not all multiples of four)
`define LSR_IDX_LINE_CTRL0       16'h0f00
`define LSR_IDX_IRQ_ENABLE       16'h0f04
`define LSR_IDX_LIVE_STATUS      16'h0f05
`define LSR_IDX_CHANGE_STATUS    16'h0f06
`define LSR_IDX_CABLE_READOUT    16'h0f09
`define LSR_IDX_SEGMENT_ONE      16'h0f0b
`define LSR_IDX_SEGMENT_TWO      16'h0f0c
`define LSR_IDX_MODE_CTRL        16'h0f10
// Field positions
`define LSR_BIT_PATTERN          0
`define LSR_BIT_SIGNAL_LOSS      1
`define LSR_BIT_SINGLE_RAIL      0
`define LSR_EQC_MSB              4
`define LSR_SEG_MSB              6
`define LSR_CABLE_MSB            5
// Arbitrary pulse mode code of the equalizer control field
`define LSR_EQC_ARBITRARY        5'h1f
// Reset values
`define LSR_RST_BYTE             8'h00
`define LSR_RST_MODE             8'h01
`endif

// ---- src/lsr_change_flag.v ----
`timescale 1ns/100ps
`include "lsr_consts.vh"
// One sticky change-detect flag with clear-on-read
module lsr_change_flag (
  // Clock and reset
  input  wire clk_sys_in,
  input  wire rst_in,
  // Control
  input  wire enable_in,
  input  wire live_in,
  input  wire clear_in,
  // Result
  output wire flag_out
);
  reg prev_q;  // Live value seen last cycle
  reg flag_q;  // Sticky change flag

  // Flag set on any edge of the live level while enabled; set beats a same-cycle clear
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      prev_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      prev_q <= live_in;
      if (enable_in && (live_in != prev_q)) begin
        flag_q <= 1'b1;
      end else if (clear_in) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign flag_out = flag_q;
endmodule // lsr_change_flag

// ---- src/lsr_apb_decode.v ----
`timescale 1ns/100ps
`include "lsr_consts.vh"
// APB address decoder: word address is four times the register index
module lsr_apb_decode (
  // Bus address
  input  wire [15:0] paddr_in,
  // Decoded selects
  output wire [7:0]  sel_out,
  output wire        hit_out
);
  function match;
    input [15:0] a;
    input [15:0] idx;
    begin
      match = (a[15:2] == idx[13:0]) && (a[1:0] == 2'b00);
    end
  endfunction

  assign sel_out[0] = match(paddr_in, `LSR_IDX_LINE_CTRL0);
  assign sel_out[1] = match(paddr_in, `LSR_IDX_IRQ_ENABLE);
  assign sel_out[2] = match(paddr_in, `LSR_IDX_LIVE_STATUS);
  assign sel_out[3] = match(paddr_in, `LSR_IDX_CHANGE_STATUS);
  assign sel_out[4] = match(paddr_in, `LSR_IDX_CABLE_READOUT);
  assign sel_out[5] = match(paddr_in, `LSR_IDX_SEGMENT_ONE);
  assign sel_out[6] = match(paddr_in, `LSR_IDX_SEGMENT_TWO);
  assign sel_out[7] = match(paddr_in, `LSR_IDX_MODE_CTRL);
  assign hit_out    = |sel_out;
endmodule // lsr_apb_decode

// ---- src/lsr_regs.v ----
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "lsr_consts.vh"
module lsr_regs (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [15:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // Receive line status inputs
  input  wire        signal_loss_live_in,
  input  wire        pattern_lock_live_in,
  input  wire [5:0]  cable_attenuation_value_in,
  // Transmit pulse shaper
  input  wire [2:0]  pulse_slot_in,
  output reg  [6:0]  pulse_amplitude_out,
  output wire        pulse_amplitude_valid_out,
  output wire [4:0]  equalizer_control_field_out,
  // Interrupt
  output wire        irq_out
);
  // Decoder results
  wire [7:0] sel;        // One select per register
  wire       hit;        // Any register addressed
  // Software state
  reg  [4:0] equalizer_control_field_q;    // Line control zero field
  reg  [1:0] irq_enable_q;                 // Per-event interrupt mask
  reg        single_rail_q;                // LIU single-rail mode
  reg  [6:0] pulse_segment_one_amplitude_q; // First slot amplitude
  reg  [6:0] pulse_segment_two_amplitude_q; // Second slot amplitude
  // Change flags
  wire       signal_loss_change_flag;
  wire       pattern_lock_change_flag;
  // Bus strobes
  wire       acc;
  wire       wr;
  wire       rd;
  wire       clr_status;
  wire       arbitrary_mode;

  assign acc        = psel_in && penable_in;
  assign wr         = acc && pwrite_in && hit && pstrb_in[0];
  assign rd         = acc && !pwrite_in;
  // Zero wait states; unmapped addresses answer with an error
  assign pready_out  = 1'b1;
  assign pslverr_out = acc && !hit;
  assign clr_status  = rd && sel[3];

  lsr_apb_decode u_dec (
    .paddr_in (paddr_in),
    .sel_out  (sel),
    .hit_out  (hit)
  );

  // Change detectors run only in single-rail mode
  lsr_change_flag u_los (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .enable_in  (single_rail_q),
    .live_in    (signal_loss_live_in),
    // Clear only what the read showed; a change caught at the setup edge survives
    .clear_in   (clr_status && prdata_out[`LSR_BIT_SIGNAL_LOSS]),
    .flag_out   (signal_loss_change_flag)
  );

  lsr_change_flag u_qrp (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .enable_in  (single_rail_q),
    .live_in    (pattern_lock_live_in),
    .clear_in   (clr_status && prdata_out[`LSR_BIT_PATTERN]),
    .flag_out   (pattern_lock_change_flag)
  );

  // Writable registers; reserved bits are simply not stored
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      equalizer_control_field_q     <= 5'h00;
      irq_enable_q                  <= 2'h0;
      single_rail_q                 <= 1'b1;
      pulse_segment_one_amplitude_q <= 7'h00;
      pulse_segment_two_amplitude_q <= 7'h00;
    end else if (wr) begin
      if (sel[0]) begin
        equalizer_control_field_q <= pwdata_in[`LSR_EQC_MSB:0];
      end
      if (sel[1]) begin
        irq_enable_q <= pwdata_in[1:0];
      end
      if (sel[5]) begin
        pulse_segment_one_amplitude_q <= pwdata_in[`LSR_SEG_MSB:0];
      end
      if (sel[6]) begin
        pulse_segment_two_amplitude_q <= pwdata_in[`LSR_SEG_MSB:0];
      end
      if (sel[7]) begin
        single_rail_q <= pwdata_in[`LSR_BIT_SINGLE_RAIL];
      end
      // Cable readout and status registers ignore writes
    end
  end

  // Read data registered at the setup edge; others read zero
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= 32'h0000_0000;
      case (1'b1)
        sel[0]: prdata_out[4:0] <= equalizer_control_field_q;
        sel[1]: prdata_out[1:0] <= irq_enable_q;
        sel[2]: prdata_out[1:0] <= single_rail_q ?
                  {signal_loss_live_in, pattern_lock_live_in} : 2'b00;
        sel[3]: prdata_out[1:0] <= {signal_loss_change_flag,
                                    pattern_lock_change_flag};
        sel[4]: prdata_out[`LSR_CABLE_MSB:0] <= cable_attenuation_value_in;
        sel[5]: prdata_out[6:0] <= pulse_segment_one_amplitude_q;
        sel[6]: prdata_out[6:0] <= pulse_segment_two_amplitude_q;
        sel[7]: prdata_out[0]   <= single_rail_q;
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Shaper amplitude only supplied in arbitrary pulse mode
  assign arbitrary_mode = (equalizer_control_field_q == `LSR_EQC_ARBITRARY);
  assign pulse_amplitude_valid_out   = arbitrary_mode;
  assign equalizer_control_field_out = equalizer_control_field_q;

  // Slot zero and one come from the two segment registers
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      pulse_amplitude_out <= 7'h00;
    end else if (!arbitrary_mode) begin
      pulse_amplitude_out <= 7'h00;
    end else begin
      case (pulse_slot_in)
        3'h0: pulse_amplitude_out <= pulse_segment_one_amplitude_q;
        3'h1: pulse_amplitude_out <= pulse_segment_two_amplitude_q;
        default: pulse_amplitude_out <= 7'h00;
      endcase
    end
  end

  // Level interrupt in single-rail mode while an enabled change flag is set
  assign irq_out = single_rail_q &&
                   ((irq_enable_q[1] && signal_loss_change_flag) ||
                    (irq_enable_q[0] && pattern_lock_change_flag));
endmodule // lsr_regs

// ---- verification/lsr_regs_props.sv ----
`timescale 1ns/100ps
// Port-level watcher; single-rail mode is assumed left at its reset value
module lsr_regs_props (
  // Clock and reset
  input logic        clk_sys_in,
  input logic        rst_in,
  // Bus
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [15:0] paddr_in,
  input logic [31:0] prdata_out,
  input logic        pslverr_out,
  // Line side
  input logic        signal_loss_live_in,
  input logic        pattern_lock_live_in,
  input logic [5:0]  cable_attenuation_value_in,
  input logic [2:0]  pulse_slot_in,
  input logic [6:0]  pulse_amplitude_out,
  input logic        pulse_amplitude_valid_out,
  input logic        irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Read access phase at one address
  sequence rd_s(a);
    psel_in && penable_in && !pwrite_in && paddr_in == a;
  endsequence
  // No live change seen at this edge
  sequence quiet_s;
    $stable(signal_loss_live_in) && $stable(pattern_lock_live_in);
  endsequence
  unmapped_err_a: assert property (psel_in && penable_in && paddr_in[15:12] != 4'h3 |->
    pslverr_out) else $error("no error on unmapped access");
  mapped_ok_a: assert property (rd_s(16'h3c2c) |-> !pslverr_out)
    else $error("error on segment read");
  cable_read_a: assert property (rd_s(16'h3c24) |->
    prdata_out == {26'h0, $past(cable_attenuation_value_in)}) else $error("cable");
  upper_zero_a: assert property (psel_in && penable_in && !pwrite_in |->
    prdata_out[31:8] == 24'h0) else $error("upper read bits set");
  live_read_a: assert property (rd_s(16'h3c14) |-> prdata_out[1:0] ==
    {$past(signal_loss_live_in), $past(pattern_lock_live_in)}) else $error("live");
  read_clear_a: assert property (quiet_s ##1 (rd_s(16'h3c18) ##0 quiet_s) |=> !irq_out)
    else $error("irq stays after clearing read");
  irq_cause_a: assert property ($rose(irq_out) |->
    $past(signal_loss_live_in, 2) != $past(signal_loss_live_in) ||
    $past(pattern_lock_live_in, 2) != $past(pattern_lock_live_in))
    else $error("irq without change");
  amp_zero_a: assert property ((!pulse_amplitude_valid_out || pulse_slot_in > 3'd1) |=>
    pulse_amplitude_out == 7'h0) else $error("amplitude outside slots");
endmodule // lsr_regs_props
bind lsr_regs lsr_regs_props chk (.clk_sys_in, .rst_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .prdata_out, .pslverr_out, .signal_loss_live_in,
  .pattern_lock_live_in, .cable_attenuation_value_in, .pulse_slot_in,
  .pulse_amplitude_out, .pulse_amplitude_valid_out, .irq_out);

// ---- verification/lsr_regs_test.sv ----
`timescale 1ns/100ps
module lsr_regs_test;
  logic        clk_sys_in, rst_in;  // Clock and reset
  logic        psel, pen, pwr;      // Bus controls
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, s1, s2;
  logic        pready, pslverr, irq, valid, loss, pat;
  logic [5:0]  cable;               // Cable attenuation value fed in
  logic [2:0]  slot;
  logic [6:0]  amp;
  logic [4:0]  eqc;
  logic [31:0] exp_q[$];            // Expected read data, oldest first
  int          error_cnt, n_compared, cyc, seed;
  // Byte lanes all on, so every write to a writable register lands
  lsr_regs uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .signal_loss_live_in(loss), .pattern_lock_live_in(pat),
    .cable_attenuation_value_in(cable), .pulse_slot_in(slot), .pulse_amplitude_out(amp),
    .pulse_amplitude_valid_out(valid), .equalizer_control_field_out(eqc), .irq_out(irq));
  initial begin
    clk_sys_in = 0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // One transfer; a read notes its expectation, t flips loss at setup
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic t);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    loss <= loss ^ t;
    if (!w) exp_q.push_back(d);
    @(posedge clk_sys_in);
    pen <= 1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
    @(posedge clk_sys_in);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read checker plus hang guard
  always @(posedge clk_sys_in) begin
    cyc++;
    if (psel && pen && !pwr) chk(prdata, exp_q.pop_front());
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    seed = 99554;
    {psel, pen, pwr, loss, pat, slot, paddr, pwdata} = 0;
    cable = 6'($random(seed));
    s1 = $random(seed);
    s2 = $random(seed);
    rst_in = 1;
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 0;
    @(posedge clk_sys_in);
    apb(0, 16'h3c18, 0, 0);
    apb(0, 16'h3c2c, 0, 0);
    apb(1, 16'h3c24, 32'hffffffff, 0);
    apb(0, 16'h3c24, {26'h0, cable}, 0);
    apb(1, 16'h3c2c, s1, 0);
    apb(1, 16'h3c30, s2, 0);
    apb(0, 16'h3c2c, {25'h0, s1[6:0]}, 0);
    apb(0, 16'h3c30, {25'h0, s2[6:0]}, 0);
    apb(0, 16'h0100, 0, 0);
    $display("register test done");
    apb(1, 16'h3c10, 32'h3, 0);
    loss <= 1;
    repeat (2) @(posedge clk_sys_in);
    chk(irq, 1);
    apb(0, 16'h3c18, 32'h2, 0);
    apb(0, 16'h3c18, 32'h0, 0);
    pat <= 1;
    @(posedge clk_sys_in);
    apb(0, 16'h3c18, 32'h1, 0);
    apb(0, 16'h3c14, 32'h3, 0);
    apb(0, 16'h3c18, 32'h0, 1);
    apb(0, 16'h3c18, 32'h2, 0);
    $display("change test done");
    apb(1, 16'h3c00, 32'h1f, 0);
    chk(eqc, 5'h1f);
    for (int i = 0; i < 8; i++) begin
      slot <= 3'(i);
      repeat (2) @(posedge clk_sys_in);
      chk(amp, i == 0 ? s1[6:0] : i == 1 ? s2[6:0] : 7'h0);
    end
    $display("pulse test done");
    end_of_test();
  end
endmodule // lsr_regs_test
